// ===== msl_map.svh
`ifndef MSL_MAP_SVH
`define MSL_MAP_SVH

`define MSL_CLK_NS      10
`define MSL_BIT_NS      14300
`define MSL_GAP_BITS    2
`define MSL_LEAD_NS     40000
`define MSL_ACC_NS      8000000
`define MSL_RDMAX_NS    150000
`define MSL_PULSE_NS    100000
`define MSL_CYC_UP(ns)  (((ns) + `MSL_CLK_NS - 1) / `MSL_CLK_NS)
`define MSL_CYC_DN(ns)  ((ns) / `MSL_CLK_NS)

`define MSL_ADDR_W      6
`define MSL_DATA_W      30
`define MSL_BODY_W      37
`define MSL_RHDR_W      7
`define MSL_CRC_W       3
`define MSL_CRC_INIT    3'h7
`define MSL_SYNC        2'h0
`define MSL_FRAME_W     42
`define MSL_WR_LAST     6'h29
`define MSL_RD_LAST     6'h0b
`define MSL_ACK_LAST    6'h21
`define MSL_KEY_ADDR    6'h24
`define MSL_KEY_DATA    30'h2781_1f77
`define MSL_TMR_W       24

`endif

// ===== msl_pkg.sv
`include "msl_map.svh"
package msl_pkg;
    typedef struct packed {
        logic                    write;
        logic                    eeprom;
        logic [`MSL_ADDR_W-1:0]  addr;
        logic [`MSL_DATA_W-1:0]  data;
    } msl_cmd_t;

    typedef struct packed {
        logic                    timedOut;
        logic                    crcOk;
        logic [`MSL_DATA_W-1:0]  word;
    } msl_rd_t;

    typedef enum logic [1:0] {K_KEY, K_WR, K_EE, K_RD} msl_kind_t;

    // Serial CRC of the n low bits, MSB first
    function automatic logic [`MSL_CRC_W-1:0] msl_crc(
        input logic [`MSL_BODY_W-1:0] bits,
        input int unsigned            n);
        logic [`MSL_CRC_W-1:0] c;
        logic                  fb;
        c = `MSL_CRC_INIT;
        for (int i = `MSL_BODY_W - 1; i >= 0; i--) begin
            if (i < n) begin
                fb = c[2] ^ bits[i];
                c  = {c[1], c[0] ^ fb, fb};
            end
        end
        return c;
    endfunction
endpackage

// ===== msl_buf2.sv
module msl_buf2 #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [AW:0]      fill, next_fill;
    logic             push, pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign inReady  = fill != (AW+1)'(DEPTH);
    assign outValid = fill != '0;
    assign outData  = mem[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        next_wrPtr = push ? bump(wrPtr) : wrPtr;
        next_rdPtr = pop ? bump(rdPtr) : rdPtr;
        next_fill  = fill + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            fill  <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            fill  <= next_fill;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    a_buf_fill_track:
        assert property (@(posedge ref_clk) disable iff (rst)
            push && !pop |=> fill == $past(fill) + 1'b1)
        else $error("Buffer fill did not grow on push");
endmodule // msl_buf2

// ===== msl_ack_rx.sv
`include "msl_map.svh"
module msl_ack_rx #(
    parameter int TO_CYC = `MSL_CYC_DN(`MSL_RDMAX_NS)
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic             lineIn,
    output logic                  done,
    output msl_pkg::msl_rd_t      res
);
    typedef enum {R_IDLE, R_HUNT, R_MEAS, R_BITS} msl_rx_st_t;

    msl_rx_st_t             st, next_st;
    logic [`MSL_TMR_W-1:0]  cnt, next_cnt, per, next_per;
    logic [5:0]             nBits, next_nBits;
    logic [`MSL_DATA_W+`MSL_CRC_W-1:0] sh, next_sh;
    logic                   linePrev, next_done, next_to;
    logic                   rise, anyEdge;
    msl_pkg::msl_rd_t       next_res;

    assign rise    = lineIn && !linePrev;
    assign anyEdge = lineIn != linePrev;

    always_comb begin
        next_st    = st;
        next_cnt   = cnt + 1'b1;
        next_per   = per;
        next_nBits = nBits;
        next_sh    = sh;
        next_done  = 1'b0;
        next_to    = 1'b0;
        case (st)
            R_IDLE: begin
                next_cnt = '0;
                if (start) begin
                    next_st = R_HUNT;
                end
            end
            R_HUNT: begin
                // First sync bit rises mid-bit
                if (rise) begin
                    next_st  = R_MEAS;
                    next_cnt = '0;
                end else if (cnt >= `MSL_TMR_W'(TO_CYC)) begin
                    next_to = 1'b1;
                end
            end
            R_MEAS: begin
                // Two sync mid edges give the sender's bit period
                if (rise) begin
                    next_per   = cnt + 1'b1;
                    next_cnt   = '0;
                    next_nBits = '0;
                    next_st    = R_BITS;
                end else if (cnt >= `MSL_TMR_W'(TO_CYC)) begin
                    next_to = 1'b1;
                end
            end
            R_BITS: begin
                if (cnt == (per >> 2)) begin
                    // Late half low means a one
                    next_sh    = {sh[`MSL_DATA_W+`MSL_CRC_W-2:0], !lineIn};
                    next_nBits = nBits + 1'b1;
                    if (nBits == `MSL_ACK_LAST) begin
                        next_done = 1'b1;
                    end
                end
                if (anyEdge && cnt > ((per * 3) >> 2)) begin
                    next_cnt = '0;
                end else if (cnt > per + (per >> 2)) begin
                    next_to = 1'b1;
                end
            end
            default: next_st = R_IDLE;
        endcase
        if (next_done || next_to) begin
            next_st = R_IDLE;
        end
        next_res = res;
        if (next_done) begin
            next_res.timedOut = 1'b0;
            next_res.word     = next_sh[`MSL_DATA_W+`MSL_CRC_W-1:`MSL_CRC_W];
            next_res.crcOk    = msl_pkg::msl_crc(
                `MSL_BODY_W'(next_res.word), `MSL_DATA_W)
                == next_sh[`MSL_CRC_W-1:0];
        end else if (next_to) begin
            next_res.timedOut = 1'b1;
            next_res.crcOk    = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st       <= R_IDLE;
            cnt      <= '0;
            per      <= '0;
            nBits    <= '0;
            sh       <= '0;
            linePrev <= 1'b0;
            done     <= 1'b0;
            res      <= '0;
        end else begin
            st       <= next_st;
            cnt      <= next_cnt;
            per      <= next_per;
            nBits    <= next_nBits;
            sh       <= next_sh;
            linePrev <= lineIn;
            done     <= next_done || next_to;
            res      <= next_res;
        end
    end

    a_rx_hunt_limit:
        assert property (@(posedge ref_clk) disable iff (rst)
            st == R_HUNT && cnt >= `MSL_TMR_W'(TO_CYC) && !rise
            |=> done && res.timedOut)
        else $error("Ack search did not time out");

    a_rx_done_single:
        assert property (@(posedge ref_clk) disable iff (rst)
            done |=> !done && st == R_IDLE)
        else $error("Receiver done not a single pulse");
endmodule // msl_ack_rx

// ===== msl_host_ctl.sv
`include "msl_map.svh"
// Operation
// - A read is started by sending a read frame on the supply.
// - After the answer ends, wait two bit times before next frame.
// - Every frame ends in a three-bit CRC, polynomial x3+x+1.
// - CRC covers all bits except the two sync bits.
// - CRC register starts at all ones each frame.
// - Access key must be sent within 8 ms of supply release.
// - Bit rate lies between 32 and 80 kbps.
// - Bit period is 13.6 to 15 us at nominal rate.
// - Bit period varies at most 11 percent within a frame.
// - After a volatile write, wait two bit times.
// - After the second programming pulse, wait two bit times.
// - First programming pulse starts 40 us after write frame end.
// - Manchester bits: falling mid edge is one, rising is zero.
// - Supply sits at nominal until the first sync pulse.
// - Supply returns to nominal within 15 us after last CRC bit.
// - Frame: two zero sync, direction, address, write data, CRC.
// - Fields go MSB first; commands on supply, answers on output.
// - Access opens with a key write to the access address.
module msl_host_ctl #(
    parameter int ACC_CYC   = `MSL_CYC_DN(`MSL_ACC_NS),
    parameter int RDTO_CYC  = `MSL_CYC_DN(`MSL_RDMAX_NS),
    parameter int PULSE_CYC = `MSL_CYC_UP(`MSL_PULSE_NS)
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              powerGood,
    input  wire logic              cmdValid,
    output logic                   cmdReady,
    input  msl_pkg::msl_cmd_t      cmd,
    output logic                   rdValid,
    input  wire logic              rdReady,
    output msl_pkg::msl_rd_t       rd,
    output logic                   supplyCoded,
    output logic                   supplyHigh,
    input  wire logic              sensPinIn,
    output logic                   sensPinOut,
    output logic                   sensPinOe,
    output logic                   accessOpen,
    output logic                   accessLost
);
    localparam int HALF_CYC = `MSL_CYC_DN(`MSL_BIT_NS / 2);
    localparam int GAP_CYC  = `MSL_CYC_UP(`MSL_GAP_BITS * `MSL_BIT_NS);
    localparam int LEAD_CYC = `MSL_CYC_UP(`MSL_LEAD_NS);
    localparam int RDLEN    = $bits(msl_pkg::msl_rd_t);

    typedef enum {S_OFF, S_IDLE, S_TX, S_ACK, S_LEAD, S_PULSE, S_PGAP,
                  S_GAP, S_LOST} msl_st_t;

    msl_st_t                 state, next_state;
    msl_pkg::msl_kind_t      kind, next_kind;
    logic [`MSL_TMR_W-1:0]   tmr, next_tmr, accTmr, next_accTmr;
    logic [`MSL_FRAME_W-1:0] sh, next_sh;
    logic [5:0]              bitCnt, next_bitCnt;
    logic                    half, next_half, pulseNo, next_pulseNo;
    logic                    next_accessOpen, next_accessLost;
    logic                    next_supplyCoded, next_supplyHigh;
    logic                    next_sensPinOe, rxStart, next_rxStart;
    logic                    rxDone, bufInReady;
    msl_pkg::msl_rd_t        rxRes;
    msl_pkg::msl_cmd_t       keyCmd;

    // Left-justified frame, MSB first
    function automatic logic [`MSL_FRAME_W-1:0] mslFrame(
        input msl_pkg::msl_cmd_t c);
        logic [`MSL_BODY_W-1:0] body;
        body = {!c.write, c.addr, c.data};
        if (c.write) begin
            mslFrame = {`MSL_SYNC, body,
                        msl_pkg::msl_crc(body, `MSL_BODY_W)};
        end else begin
            mslFrame = {`MSL_SYNC, body[`MSL_BODY_W-1:`MSL_DATA_W],
                        msl_pkg::msl_crc(
                            `MSL_BODY_W'(body[`MSL_BODY_W-1:`MSL_DATA_W]),
                            `MSL_RHDR_W),
                        `MSL_DATA_W'(0)};
        end
    endfunction

    assign keyCmd   = '{write: 1'b1, eeprom: 1'b0, addr: `MSL_KEY_ADDR,
                        data: `MSL_KEY_DATA};
    assign cmdReady = state == S_IDLE && bufInReady;
    assign sensPinOut = sensPinOe;

    always_comb begin
        next_state      = state;
        next_kind       = kind;
        next_tmr        = (tmr != '0) ? tmr - 1'b1 : tmr;
        next_sh         = sh;
        next_bitCnt     = bitCnt;
        next_half       = half;
        next_pulseNo    = pulseNo;
        next_accessOpen = accessOpen;
        next_accessLost = accessLost;
        next_accTmr     = accTmr;
        next_rxStart    = 1'b0;
        case (state)
            S_OFF: begin
                next_accTmr = '0;
                if (powerGood) begin
                    next_state  = S_TX;
                    next_kind   = msl_pkg::K_KEY;
                    next_sh     = mslFrame(keyCmd);
                    next_bitCnt = `MSL_WR_LAST;
                    next_half   = 1'b0;
                    next_tmr    = `MSL_TMR_W'(HALF_CYC - 1);
                end
            end
            S_IDLE: begin
                if (cmdValid && cmdReady) begin
                    next_state  = S_TX;
                    next_sh     = mslFrame(cmd);
                    next_bitCnt = cmd.write ? `MSL_WR_LAST : `MSL_RD_LAST;
                    next_kind   = !cmd.write ? msl_pkg::K_RD
                                : cmd.eeprom ? msl_pkg::K_EE : msl_pkg::K_WR;
                    next_half   = 1'b0;
                    next_tmr    = `MSL_TMR_W'(HALF_CYC - 1);
                end
            end
            S_TX: begin
                if (tmr == '0) begin
                    next_tmr = `MSL_TMR_W'(HALF_CYC - 1);
                    if (!half) begin
                        next_half = 1'b1;
                    end else if (bitCnt != '0) begin
                        next_half   = 1'b0;
                        next_bitCnt = bitCnt - 1'b1;
                        next_sh     = {sh[`MSL_FRAME_W-2:0], 1'b0};
                    end else begin
                        case (kind)
                            msl_pkg::K_RD: begin
                                next_state   = S_ACK;
                                next_rxStart = 1'b1;
                            end
                            msl_pkg::K_EE: begin
                                next_state   = S_LEAD;
                                next_pulseNo = 1'b0;
                                next_tmr     = `MSL_TMR_W'(LEAD_CYC - 1);
                            end
                            msl_pkg::K_KEY: begin
                                next_accessOpen = 1'b1;
                                next_state = S_GAP;
                                next_tmr   = `MSL_TMR_W'(GAP_CYC - 1);
                            end
                            default: begin
                                next_state = S_GAP;
                                next_tmr   = `MSL_TMR_W'(GAP_CYC - 1);
                            end
                        endcase
                    end
                end
            end
            S_ACK: begin
                // Last sample lands inside the answer's final half bit, a quarter bit before its end
                if (rxDone) begin
                    next_state = S_GAP;
                    next_tmr   = `MSL_TMR_W'(GAP_CYC + HALF_CYC - 1);
                end
            end
            S_LEAD, S_PGAP: begin
                if (tmr == '0) begin
                    next_state = S_PULSE;
                    next_tmr   = `MSL_TMR_W'(PULSE_CYC - 1);
                end
            end
            S_PULSE: begin
                if (tmr == '0) begin
                    next_pulseNo = 1'b1;
                    next_state   = pulseNo ? S_GAP : S_PGAP;
                    next_tmr     = `MSL_TMR_W'(GAP_CYC - 1);
                end
            end
            S_GAP: begin
                if (tmr == '0) begin
                    next_state = S_IDLE;
                end
            end
            S_LOST: next_state = S_LOST;
            default: next_state = S_OFF;
        endcase
        // Key deadline counts from supply release
        if (state != S_OFF && !accessOpen) begin
            next_accTmr = accTmr + 1'b1;
            if (accTmr >= `MSL_TMR_W'(ACC_CYC - 1)) begin
                next_accessLost = 1'b1;
                next_state      = S_LOST;
            end
        end
        if (!powerGood) begin
            next_state      = S_OFF;
            next_accessOpen = 1'b0;
            next_accessLost = 1'b0;
        end
        // Nominal supply outside frames, coded levels inside
        next_supplyCoded = next_state == S_TX;
        next_supplyHigh  = (next_state == S_TX)
                         ? next_sh[`MSL_FRAME_W-1] ^ next_half
                         : 1'b1;
        next_sensPinOe   = next_state == S_PULSE;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state       <= S_OFF;
            kind        <= msl_pkg::K_KEY;
            tmr         <= '0;
            accTmr      <= '0;
            sh          <= '0;
            bitCnt      <= '0;
            half        <= 1'b0;
            pulseNo     <= 1'b0;
            accessOpen  <= 1'b0;
            accessLost  <= 1'b0;
            supplyCoded <= 1'b0;
            supplyHigh  <= 1'b1;
            sensPinOe   <= 1'b0;
            rxStart     <= 1'b0;
        end else begin
            state       <= next_state;
            kind        <= next_kind;
            tmr         <= next_tmr;
            accTmr      <= next_accTmr;
            sh          <= next_sh;
            bitCnt      <= next_bitCnt;
            half        <= next_half;
            pulseNo     <= next_pulseNo;
            accessOpen  <= next_accessOpen;
            accessLost  <= next_accessLost;
            supplyCoded <= next_supplyCoded;
            supplyHigh  <= next_supplyHigh;
            sensPinOe   <= next_sensPinOe;
            rxStart     <= next_rxStart;
        end
    end

    msl_ack_rx #(
        .TO_CYC (RDTO_CYC)
    ) u_rx (
        .ref_clk (ref_clk),
        .rst     (rst),
        .start   (rxStart),
        .lineIn  (sensPinIn),
        .done    (rxDone),
        .res     (rxRes)
    );

    msl_buf2 #(
        .WIDTH (RDLEN),
        .DEPTH (2)
    ) u_buf (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inValid  (rxDone),
        .inReady  (bufInReady),
        .inData   (rxRes),
        .outValid (rdValid),
        .outReady (rdReady),
        .outData  (rd)
    );

    // Quiet-time counter for gap checks
    logic [`MSL_TMR_W-1:0] quietCnt;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            quietCnt <= '0;
        end else if (supplyCoded || sensPinOe || state == S_ACK) begin
            quietCnt <= '0;
        end else if (quietCnt != '1) begin
            quietCnt <= quietCnt + 1'b1;
        end
    end

    a_frame_gap:
        assert property (@(posedge ref_clk) disable iff (rst)
            $rose(supplyCoded) && accessOpen
            |-> $past(quietCnt) >= `MSL_TMR_W'(GAP_CYC))
        else $error("Frame started before the two-bit gap");

    a_mid_bit_edge:
        assert property (@(posedge ref_clk) disable iff (rst)
            supplyCoded && $rose(half) |-> supplyHigh != $past(supplyHigh))
        else $error("Missing mid-bit transition");

    a_pulse_lead:
        assert property (@(posedge ref_clk) disable iff (rst)
            $rose(sensPinOe) && !pulseNo
            |-> quietCnt >= `MSL_TMR_W'(LEAD_CYC))
        else $error("Programming pulse too soon after write");

    a_lost_quiet:
        assert property (@(posedge ref_clk) disable iff (rst)
            accessLost |-> !cmdReady && !supplyCoded && !sensPinOe)
        else $error("Activity after missed key deadline");

    a_key_first:
        assert property (@(posedge ref_clk) disable iff (rst)
            $rose(supplyCoded) && !accessOpen |-> kind == msl_pkg::K_KEY)
        else $error("First frame was not the access key");

    a_sync_zero:
        assert property (@(posedge ref_clk) disable iff (rst)
            $rose(supplyCoded) |-> !supplyHigh ##1 !supplyHigh)
        else $error("Frame did not open with a zero sync bit");
endmodule // msl_host_ctl

// ===== msl_dev_model.sv
module msl_dev_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic powerGood,
    input  wire logic supplyCoded,
    input  wire logic supplyHigh,
    input  wire logic sensPinOe,
    input  wire logic corruptAck,
    input  wire logic silent,
    output logic      sensPinIn,
    output int        errs,
    output int        pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 1430;
    localparam int AB = 200;
    logic [41:0] sh;
    logic [29:0] mem [64];
    logic [34:0] ack;
    logic        keyOk, ok, pc, po;
    int          ph, quiet, since, txc, n, k;
    function automatic logic [2:0] crc3(input logic [38:0] v, input int m);
        logic [2:0] c;
        logic       fb;
        c = 3'h7;
        for (int i = m - 1; i >= 0; i--) begin
            fb = c[2] ^ v[i];
            c = {c[1], c[0] ^ fb, fb};
        end
        return c;
    endfunction
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {keyOk, pc, po} = 3'h0;
            sensPinIn <= 1'b0;
            errs = 0;
            pulses = 0;
            since = 0;
            txc = 0;
            quiet = 2 * BIT;
        end else begin
            since = powerGood ? since + 1 : 0;
            quiet = quiet + 1;
            if (!supplyCoded && !supplyHigh) errs++;
            if (supplyCoded && !pc && quiet < 2 * BIT) errs++;
            if (sensPinOe && !po) begin
                if (pulses % 2 == 0 && quiet < 4000) errs++;
                pulses++;
            end
            if (supplyCoded) begin
                ph = pc ? ph + 1 : 0;
                if (ph % BIT == BIT / 4) sh = {sh[40:0], supplyHigh};
                if (ph % BIT == BIT * 3 / 4 && supplyHigh == sh[0]) errs++;
            end else if (pc) begin
                n = (ph + 1) / BIT;
                ok = (ph + 1) % BIT == 0 && sh[n-1 -: 2] == 2'b00;
                ok = ok && crc3(sh[41:3], n - 5) == sh[2:0];
                if (ok && n == 42 && !sh[39]) begin
                    if (sh[38:33] == 6'h24 && sh[32:3] == 30'h2781_1f77
                        && since <= 800000) keyOk = 1;
                    else if (keyOk) mem[sh[38:33]] = sh[32:3];
                end else if (ok && n == 12 && sh[9] && keyOk && !silent) begin
                    ack = {2'b00, mem[sh[8:3]],
                           crc3({9'h0, mem[sh[8:3]]}, 30) ^ {2'b00, corruptAck}};
                    txc = 1;
                end else if (!ok || n != 12) errs++;
            end
            if (txc > 0) begin
                txc++;
                k = (txc - 4952) / AB;
                if (txc > 4951 + 35 * AB) begin
                    txc = 0;
                    sensPinIn <= 1'b0;
                end else if (txc > 4951)
                    sensPinIn <= ((txc - 4952) % AB < AB / 2) ~^ ack[34 - k];
            end
            if (supplyCoded || sensPinOe || txc > 0) quiet = 0;
            pc = supplyCoded;
            po = sensPinOe;
        end
    end
endmodule // msl_dev_model

// ===== tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, powerGood, cmdValid, rdReady, corruptAck, silent;
    logic cmdReady, rdValid, supplyCoded, supplyHigh, sensPinIn;
    logic sensPinOut, sensPinOe, accessOpen, accessLost;
    logic [31:0]       v;
    msl_pkg::msl_cmd_t cmd;
    msl_pkg::msl_rd_t  rd;
    int                errs, pulses, mismatches, cmp_count;
    msl_host_ctl #(.PULSE_CYC(200)) u_dut (.ref_clk, .rst, .powerGood,
        .cmdValid, .cmdReady, .cmd, .rdValid, .rdReady, .rd, .supplyCoded,
        .supplyHigh, .sensPinIn, .sensPinOut, .sensPinOe, .accessOpen,
        .accessLost);
    msl_dev_model u_dev (.ref_clk, .rst, .powerGood, .supplyCoded,
        .supplyHigh, .sensPinOe, .corruptAck, .silent, .sensPinIn, .errs,
        .pulses);
    task automatic close_out;
        if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic waitReady;
        for (int i = 0; i < 200000 && cmdReady !== 1'b1; i++)
            @(negedge ref_clk);
        if (cmdReady !== 1'b1) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic send(input logic ee, input logic [29:0] d);
        waitReady();
        cmdValid = 1;
        cmd = '{d != 0, ee, 6'h05, d};
        @(negedge ref_clk);
        cmdValid = 0;
    endtask
    task automatic popRd;
        for (int i = 0; i < 100000 && rdValid !== 1'b1; i++)
            @(negedge ref_clk);
        if (rdValid !== 1'b1) begin
            mismatches++;
            close_out();
        end
        v = rd;
        rdReady = 1;
        @(negedge ref_clk);
        rdReady = 0;
    endtask
    task automatic t_key;
        cmp({31'h0, cmdReady}, 32'h0000_0000);
        waitReady();
        cmp({30'h0, accessOpen, accessLost}, 32'h0000_0002);
    endtask
    task automatic t_eeprom;
        send(1, 30'h2a5c_3e1d);
        waitReady();
        cmp(pulses, 32'h0000_0002);
    endtask
    task automatic t_buffer;
        send(0, 30'h0000_0000);
        waitReady();
        corruptAck = 1;
        send(0, 30'h0000_0000);
        repeat (40000) @(negedge ref_clk);
        cmp({31'h0, cmdReady}, 32'h0000_0000);
        corruptAck = 0;
        popRd();
        cmp(v, {2'b01, 30'h2a5c_3e1d});
        popRd();
        cmp(v, {2'b00, 30'h2a5c_3e1d});
    endtask
    task automatic t_silent;
        silent = 1;
        send(0, 30'h0000_0000);
        popRd();
        cmp({30'h0, v[31:30]}, 32'h0000_0002);
        silent = 0;
        waitReady();
        cmp(errs, 32'h0000_0000);
    endtask
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {rst, powerGood, cmdValid, rdReady, corruptAck, silent} = 6'b11_0000;
        cmd = '0;
        mismatches = 0;
        cmp_count = 0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 0;
        t_key();
        t_eeprom();
        t_buffer();
        t_silent();
        close_out();
    end
endmodule // tb
